// >>> common/boot_loader_regs.vh
`ifndef BOOT_LOADER_REGS_VH
`define BOOT_LOADER_REGS_VH
// bus timing and clock rate
`define CLK_HZ 200000000
`define STD_HZ 100000
`define FAST_HZ 400000
`define BIT_QUARTERS 4
// eeprom device address and transfer direction
`define EE_DEV_ADDR 7'h50
`define I2C_WR 1'b0
`define I2C_RD 1'b1
// image layout
`define IMG_SPEED_ADDR 10'h001
`define IMG_SPEED_BIT 7
`define IMG_CRC_ADDR 10'h39e
`define IMG_LAST_DATA 10'h39d
`define IMG_FIRST 10'h000
// crc and retries
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define MAX_RETRY 2'h3
// page layout of the register map
`define PAGE_SEL_OFS 7'h7f
`define PAGE_SHIFT 7
`endif

// >>> src/bus_bit_engine.v
`timescale 1ns/1ps
`include "boot_loader_regs.vh"
// open-drain byte engine: start, stop, byte write or byte read
module bus_bit_engine #(
  parameter TO_CYCLES = 20000
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // command
  input wire [15:0] half_div,
  input wire [2:0] cmd,
  input wire cmd_go,
  input wire [7:0] tx_byte,
  input wire rx_ack_bit,
  output reg busy,
  output reg done,
  output reg [7:0] rx_byte_r,
  output reg nack_r,
  output reg tmo_r,
  // synchronised pin levels
  input wire scl_in,
  input wire sda_in,
  // pin drive (1 = pull low)
  output reg scl_low_r,
  output reg sda_low_r
);
  localparam C_START = 3'd1;
  localparam C_STOP = 3'd2;
  localparam C_WR = 3'd3;
  localparam C_RD = 3'd4;
  reg [2:0] op_r;
  reg [3:0] bit_r;
  reg [1:0] ph_r;
  reg [15:0] cnt_r;
  reg [8:0] sh_r;
  reg [31:0] to_r;
  wire tick = (cnt_r == 16'h0000);
  // quarter-bit phase stepper; slave never stretches, so bus runs open loop
  always @(posedge clk) begin
    done <= 1'b0;
    if (!rst_b) begin
      busy <= 1'b0;
      op_r <= 3'h0;
      bit_r <= 4'h0;
      ph_r <= 2'h0;
      cnt_r <= 16'h0000;
      sh_r <= 9'h000;
      to_r <= 32'h0;
      rx_byte_r <= 8'h00;
      nack_r <= 1'b0;
      tmo_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (!busy) begin
      if (cmd_go) begin
        busy <= 1'b1;
        op_r <= cmd;
        bit_r <= 4'h0;
        ph_r <= 2'h0;
        cnt_r <= half_div;
        nack_r <= 1'b0;
        tmo_r <= 1'b0;
        to_r <= 32'h0;
        sh_r <= (cmd == C_RD) ? {8'hff, ~rx_ack_bit} : {tx_byte, 1'b1};
      end
    end else begin
      cnt_r <= tick ? half_div : cnt_r - 16'h0001;
      // ack wait guard: clock held high with data still floating counts as no response
      if (op_r == C_WR && bit_r == 4'h8 && ph_r == 2'h2 && sda_in)
        to_r <= to_r + 32'h1;
      if (tick) begin
        ph_r <= ph_r + 2'h1;
        case (op_r)
          C_START: begin
            case (ph_r)
              2'h0: begin sda_low_r <= 1'b0; scl_low_r <= 1'b0; end
              2'h1: sda_low_r <= 1'b1;
              2'h2: scl_low_r <= 1'b1;
              default: begin busy <= 1'b0; done <= 1'b1; end
            endcase
          end
          C_STOP: begin
            case (ph_r)
              2'h0: begin scl_low_r <= 1'b1; sda_low_r <= 1'b1; end
              2'h1: scl_low_r <= 1'b0;
              2'h2: sda_low_r <= 1'b0;
              default: begin busy <= 1'b0; done <= 1'b1; end
            endcase
          end
          C_WR, C_RD: begin
            case (ph_r)
              2'h0: sda_low_r <= ~sh_r[8];
              2'h1: scl_low_r <= 1'b0;
              2'h2: begin
                sh_r <= {sh_r[7:0], sda_in};
                if (bit_r == 4'h8) begin
                  if (op_r == C_WR) begin
                    nack_r <= sda_in;
                    tmo_r <= sda_in && (to_r >= TO_CYCLES);
                  end else begin
                    rx_byte_r <= sh_r[7:0];
                  end
                end
              end
              default: begin
                scl_low_r <= 1'b1;
                // data stays put as the clock falls; phase 0 of the next bit, or of the next command after the ack bit, moves it
                if (bit_r == 4'h8) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                end
                bit_r <= bit_r + 4'h1;
              end
            endcase
          end
          default: begin busy <= 1'b0; done <= 1'b1; end
        endcase
      end
    end
  end
endmodule

// >>> src/eeprom_boot_loader.v
`timescale 1ns/1ps
`include "boot_loader_regs.vh"
// Operation
// - run only when both mode pins high
// - start after reset release and calibration
// - eeprom addressed as 7-bit 1010000
// - short read at 100 kHz, then full read
// - speed bit selects 400 kHz full read
// - one block read 0x000..0x39E into map
// - always two word-address bytes
// - crc-8 poly 0x07 over 0x000..0x39D
// - nack, crc mismatch, timeout fail attempt
// - retry three times then abort flag
// - abort holds both pins low
// - success leaves pins high, done flag
// - host port locked out during loading
// - sole master, read only, no stretching
// - page select at 0x7F targets page
module eeprom_boot_loader #(
  parameter TO_CYCLES = 20000,
  parameter SYS_HZ = `CLK_HZ
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // device status inputs
  input wire calib_done,
  input wire fail_clear,
  // bus clock pin
  input wire loader_bus_clock_pin_in,
  output wire loader_bus_clock_pin_out,
  output wire loader_bus_clock_pin_oe,
  // bus data pin
  input wire loader_bus_data_pin_in,
  output wire loader_bus_data_pin_out,
  output wire loader_bus_data_pin_oe,
  // map write port
  output reg map_wr_r,
  output reg [6:0] map_page_r,
  output reg [6:0] map_offset_r,
  output reg [7:0] map_data_r,
  // status
  output reg boot_done_r,
  output reg boot_fail_r,
  output wire host_port_enable,
  output reg loading_r
);
  localparam S_IDLE = 4'd0;
  localparam S_START = 4'd1;
  localparam S_DEVW = 4'd2;
  localparam S_AHI = 4'd3;
  localparam S_ALO = 4'd4;
  localparam S_RSTART = 4'd5;
  localparam S_DEVR = 4'd6;
  localparam S_READ = 4'd7;
  localparam S_STOP = 4'd8;
  localparam S_EVAL = 4'd9;
  localparam S_OK = 4'd10;
  localparam S_FAIL = 4'd11;
  localparam S_OFF = 4'd12;
  localparam S_RDGO = 4'd13;
  // quarter-bit dividers, cut to the engine's counter width on purpose
  localparam integer STD_DIV_I = SYS_HZ / (`STD_HZ * `BIT_QUARTERS) - 1;
  localparam integer FAST_DIV_I = SYS_HZ / (`FAST_HZ * `BIT_QUARTERS) - 1;
  localparam [15:0] STD_DIV = STD_DIV_I[15:0];
  localparam [15:0] FAST_DIV = FAST_DIV_I[15:0];

  function [7:0] crc_step;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] x;
    begin
      x = c ^ d;
      for (i = 0; i < 8; i = i + 1)
        x = x[7] ? ((x << 1) ^ `CRC_POLY) : (x << 1);
      crc_step = x;
    end
  endfunction

  reg [1:0] scl_s, sda_s;
  reg armed_r, mode_ok_r;
  reg [3:0] st_r;
  reg [1:0] retry_r;
  reg full_r, fast_r, go_r, fail_r;
  reg [2:0] cmd_r;
  reg [7:0] tx_r;
  reg [9:0] addr_r;
  reg [7:0] crc_r;
  wire done, nack, tmo, scl_low, sda_low;
  wire [7:0] rx;
  wire [9:0] last_addr = full_r ? `IMG_CRC_ADDR : `IMG_SPEED_ADDR;

  // two-flop synchronisers on both pins; they run through reset so the
  // straps caught at release are the real pin levels
  always @(posedge clk) begin
    scl_s <= {scl_s[0], loader_bus_clock_pin_in};
    sda_s <= {sda_s[0], loader_bus_data_pin_in};
  end

  // mode straps caught on first cycle after reset release
  always @(posedge clk) begin
    if (!rst_b) begin
      armed_r <= 1'b1;
      mode_ok_r <= 1'b0;
    end else if (armed_r) begin
      armed_r <= 1'b0;
      mode_ok_r <= scl_s[1] & sda_s[1];
    end
  end

  bus_bit_engine #(.TO_CYCLES(TO_CYCLES)) u_eng (
    .clk(clk),
    .rst_b(rst_b),
    .half_div(fast_r ? FAST_DIV : STD_DIV),
    .cmd(cmd_r),
    .cmd_go(go_r),
    .tx_byte(tx_r),
    .rx_ack_bit(addr_r != last_addr),
    .busy(),
    .done(done),
    .rx_byte_r(rx),
    .nack_r(nack),
    .tmo_r(tmo),
    .scl_in(scl_s[1]),
    .sda_in(sda_s[1]),
    .scl_low_r(scl_low),
    .sda_low_r(sda_low)
  );

  // abort forces both pins low; otherwise the engine drives open-drain
  assign loader_bus_clock_pin_out = 1'b0;
  assign loader_bus_data_pin_out = 1'b0;
  assign loader_bus_clock_pin_oe = (st_r == S_FAIL) | scl_low;
  assign loader_bus_data_pin_oe = (st_r == S_FAIL) | sda_low;
  assign host_port_enable = ~loading_r & ~armed_r;

  // boot sequencer
  always @(posedge clk) begin
    go_r <= 1'b0;
    map_wr_r <= 1'b0;
    if (!rst_b) begin
      st_r <= S_IDLE;
      retry_r <= 2'h0;
      full_r <= 1'b0;
      fast_r <= 1'b0;
      fail_r <= 1'b0;
      cmd_r <= 3'h0;
      tx_r <= 8'h00;
      addr_r <= `IMG_FIRST;
      crc_r <= `CRC_INIT;
      map_page_r <= 7'h00;
      map_offset_r <= 7'h00;
      map_data_r <= 8'h00;
      boot_done_r <= 1'b0;
      boot_fail_r <= 1'b0;
      loading_r <= 1'b1;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (!armed_r && !mode_ok_r) begin
            loading_r <= 1'b0; // host serial port mode instead
            st_r <= S_OFF;
          end else if (!armed_r && calib_done) begin
            full_r <= 1'b0;
            fast_r <= 1'b0; // short read always at 100 kHz
            st_r <= S_START;
          end
        end
        S_START: begin
          // every attempt starts from image address zero, crc cleared
          addr_r <= `IMG_FIRST;
          crc_r <= `CRC_INIT;
          fail_r <= 1'b0;
          map_page_r <= 7'h00;
          cmd_r <= 3'd1;
          go_r <= 1'b1;
          st_r <= S_DEVW;
        end
        S_DEVW, S_AHI, S_ALO, S_RSTART, S_DEVR, S_RDGO: begin
          if (done) begin
            if (nack || tmo) begin
              fail_r <= 1'b1;
              cmd_r <= 3'd2;
              go_r <= 1'b1;
              st_r <= S_STOP;
            end else begin
              go_r <= 1'b1;
              st_r <= st_r + 4'd1;
              case (st_r)
                S_DEVW: begin cmd_r <= 3'd3; tx_r <= {`EE_DEV_ADDR, `I2C_WR}; end
                S_AHI: begin cmd_r <= 3'd3; tx_r <= 8'h00; end
                S_ALO: begin cmd_r <= 3'd3; tx_r <= 8'h00; end
                S_RSTART: cmd_r <= 3'd1;
                // repeated start done: send the read address byte
                S_DEVR: begin
                  cmd_r <= 3'd3;
                  tx_r <= {`EE_DEV_ADDR, `I2C_RD};
                  st_r <= S_RDGO;
                end
                // read address acknowledged: fetch the first data byte
                default: begin
                  cmd_r <= 3'd4;
                  st_r <= S_READ;
                end
              endcase
            end
          end
        end
        S_READ: begin
          if (done) begin
            // byte lands at matching map offset, page from the last byte read at offset 0x7F
            map_wr_r <= full_r;
            map_data_r <= rx;
            map_offset_r <= addr_r[6:0];
            if (full_r && addr_r[6:0] == `PAGE_SEL_OFS)
              map_page_r <= rx[6:0];
            if (addr_r <= `IMG_LAST_DATA)
              crc_r <= crc_step(crc_r, rx);
            else if (rx != crc_r)
              fail_r <= full_r;
            if (addr_r == `IMG_SPEED_ADDR && !full_r)
              fast_r <= rx[`IMG_SPEED_BIT];
            if (addr_r == last_addr) begin
              cmd_r <= 3'd2;
              st_r <= S_STOP;
            end else begin
              cmd_r <= 3'd4;
            end
            go_r <= 1'b1;
            addr_r <= addr_r + 10'h001;
          end
        end
        S_STOP: begin
          if (done)
            st_r <= S_EVAL;
        end
        S_EVAL: begin
          if (fail_r) begin
            // retry from short read, three restarts then abort
            if (retry_r == `MAX_RETRY) begin
              boot_fail_r <= 1'b1;
              st_r <= S_FAIL;
            end else begin
              retry_r <= retry_r + 2'h1;
              full_r <= 1'b0;
              fast_r <= 1'b0;
              st_r <= S_START;
            end
          end else if (!full_r) begin
            full_r <= 1'b1;
            st_r <= S_START;
          end else begin
            boot_done_r <= 1'b1;
            loading_r <= 1'b0;
            st_r <= S_OK;
          end
        end
        S_FAIL: begin
          if (fail_clear) begin
            boot_fail_r <= 1'b0;
            loading_r <= 1'b0;
            st_r <= S_OFF;
          end
        end
        S_OK, S_OFF: st_r <= st_r;
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> testbench/boot_loader_props.sv
`timescale 1ns/1ps
// port-level checks of the boot loader
module boot_loader_props #(
  parameter TO_CYCLES = 20000
) (
  // clock, reset and inputs
  input wire clk,
  input wire rst_b,
  input wire calib_done,
  input wire fail_clear,
  // watched outputs
  input wire loader_bus_clock_pin_oe,
  input wire loader_bus_data_pin_oe,
  input wire map_wr_r,
  input wire boot_done_r,
  input wire boot_fail_r,
  input wire host_port_enable,
  input wire loading_r
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // both pins pulled low, or both released
  wire lo2 = loader_bus_clock_pin_oe && loader_bus_data_pin_oe;
  wire hi2 = !loader_bus_clock_pin_oe && !loader_bus_data_pin_oe;
  a_idle_before_calib: assert property (!calib_done |-> hi2)
    else $error("bus driven before calibration");
  a_abort_pins_low: assert property (boot_fail_r && $past(boot_fail_r) && !fail_clear |-> lo2)
    else $error("pins not held low after abort");
  a_fail_holds: assert property (boot_fail_r && !fail_clear |=> boot_fail_r)
    else $error("failure flag dropped by itself");
  a_clear_releases: assert property (boot_fail_r && fail_clear |-> ##[1:3] hi2 && !boot_fail_r)
    else $error("clear did not release pins");
  a_done_pins_high: assert property (boot_done_r && $past(boot_done_r) |-> hi2)
    else $error("pins driven after load");
  a_done_sticky: assert property (boot_done_r |=> boot_done_r && !map_wr_r)
    else $error("done flag lost or map written");
  a_host_locked: assert property (loading_r |-> !host_port_enable)
    else $error("host port open while loading");
  a_host_after_done: assert property (boot_done_r |=> host_port_enable && !loading_r)
    else $error("host port closed after load");
  a_wr_single: assert property (map_wr_r |=> !map_wr_r [*8])
    else $error("map write pulses too close");
  a_flags_apart: assert property (!(boot_done_r && boot_fail_r))
    else $error("done and failure both set");
endmodule
bind eeprom_boot_loader boot_loader_props #(.TO_CYCLES(TO_CYCLES)) props (
  .clk(clk), .rst_b(rst_b), .calib_done(calib_done), .fail_clear(fail_clear),
  .loader_bus_clock_pin_oe(loader_bus_clock_pin_oe),
  .loader_bus_data_pin_oe(loader_bus_data_pin_oe), .map_wr_r(map_wr_r),
  .boot_done_r(boot_done_r), .boot_fail_r(boot_fail_r),
  .host_port_enable(host_port_enable), .loading_r(loading_r));

// >>> testbench/ee_model.sv
`timescale 1ns/1ps
// behavioural serial eeprom: two word-address bytes, sequential read
module ee_model (
  // bus wires and test control
  input wire scl,
  input wire sda,
  input wire mute,
  // data line pull (1 = low)
  output reg sda_pull
);
  reg [7:0] mem [0:1023];
  reg [7:0] sh;
  reg [7:0] first_byte;
  reg [9:0] ptr;
  reg act, rd, own;
  integer bitn, byten, starts;
  realtime t_rise, per;
  initial begin
    sda_pull = 0;
    act = 0;
    starts = 0;
    t_rise = 0;
  end
  // start or repeated start restarts byte framing
  always @(negedge sda) if (scl) begin
    act = 1;
    rd = 0;
    own = 0;
    bitn = 0;
    byten = 0;
    starts = starts + 1;
  end
  // stop ends the transfer
  always @(posedge sda) if (scl) act = 0;
  // sample on the rising clock edge
  always @(posedge scl) begin
    per = $realtime - t_rise;
    t_rise = $realtime;
    if (act) begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      else if (!own && sda)
        act = 0; // master declined further data
      else if (!own)
        ptr = ptr + 1;
      bitn = bitn + 1;
    end
  end
  // drive on the falling clock edge; a released line floats high
  always @(negedge scl) if (act) begin
    if (bitn == 9) begin
      bitn = 0;
      own = 0;
    end
    if (bitn == 8 && !rd) begin
      own = 1;
      if (byten == 0) begin
        first_byte = sh;
        rd = sh[0];
        own = (sh[7:1] == 7'h50) && !mute;
      end else if (byten == 1)
        ptr[9:8] = sh[1:0];
      else
        ptr[7:0] = sh;
      byten = byten + 1;
      sda_pull = own;
      act = own;
    end else
      sda_pull = rd && bitn < 8 && !mem[ptr][7 - bitn];
  end
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
// strap refusal, abort after retries, full image load
module tb_top;
  // divider base handed to the dut so that a whole image fits the run
  localparam BUS_HZ = 3200000;
  // clock period times clocks per bus bit
  localparam real STD_NS = 5.0 * BUS_HZ / 100000.0;
  localparam real FAST_NS = 5.0 * BUS_HZ / 400000.0;
  localparam [7:0] BOARD_ADDR = 8'h5a; // arbitrary board slave address
  localparam [7:0] TAIL_DEFAULT = 8'h00;
  reg clk, rst_b, calib_done, fail_clear, strap_lo, mute;
  wire scl_oe, sda_oe, sda_pull, map_wr_r, boot_done_r, boot_fail_r;
  wire host_port_enable, loading_r;
  wire [6:0] map_page_r, map_offset_r;
  wire [7:0] map_data_r;
  reg [7:0] img [0:1023];
  reg [7:0] c;
  reg [6:0] pg;
  integer err_count, total_checks, widx, i;
  // open-drain wires with pull-ups
  wire scl = !scl_oe;
  wire sda = !(sda_oe || sda_pull || strap_lo);
  eeprom_boot_loader #(.TO_CYCLES(100), .SYS_HZ(BUS_HZ)) dut (
    .clk(clk), .rst_b(rst_b), .calib_done(calib_done), .fail_clear(fail_clear),
    .loader_bus_clock_pin_in(scl), .loader_bus_clock_pin_out(),
    .loader_bus_clock_pin_oe(scl_oe), .loader_bus_data_pin_in(sda),
    .loader_bus_data_pin_out(), .loader_bus_data_pin_oe(sda_oe),
    .map_wr_r(map_wr_r), .map_page_r(map_page_r), .map_offset_r(map_offset_r),
    .map_data_r(map_data_r), .boot_done_r(boot_done_r), .boot_fail_r(boot_fail_r),
    .host_port_enable(host_port_enable), .loading_r(loading_r));
  ee_model ee (.scl(scl), .sda(sda), .mute(mute), .sda_pull(sda_pull));
  // system clock
  initial begin
    clk = 0;
    forever #2.5 clk = !clk;
  end
  task automatic chk(input bit ok, input string m);
    total_checks = total_checks + 1;
    if (!ok) begin
      err_count = err_count + 1;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  function automatic [7:0] crc8(input [7:0] cr, input [7:0] d);
    integer k;
    cr = cr ^ d;
    for (k = 0; k < 8; k = k + 1)
      cr = cr[7] ? {cr[6:0], 1'b0} ^ 8'h07 : {cr[6:0], 1'b0};
    return cr;
  endfunction
  // reset, then calibration finishes after a random delay
  task start(input reg m);
    integer d;
    mute <= m;
    rst_b <= 1'b0;
    calib_done <= 1'b0;
    widx = 0;
    pg = 0;
    ee.starts = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    d = $urandom_range(40, 2);
    repeat (d) @(posedge clk);
    calib_done <= 1'b1;
  endtask
  task wait_end(input integer lim);
    integer n;
    n = 0;
    while (boot_done_r !== 1'b1 && boot_fail_r !== 1'b1 && n < lim) begin
      @(posedge clk);
      n = n + 1;
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // every map write against the image, in address order
  always @(posedge clk) if (map_wr_r === 1'b1) begin
    chk(map_offset_r === widx[6:0] && map_data_r === img[widx], "map write");
    if (widx[6:0] != 7'h7f)
      chk(map_page_r === pg, "map page");
    else
      pg = img[widx][6:0];
    if (widx == 10)
      chk(ee.per > FAST_NS - 1.0 && ee.per < FAST_NS + 1.0, "fast bus period");
    widx = widx + 1;
  end
  // hang guard, a little beyond the expected length of all tests
  initial begin
    #500000;
    err_count = err_count + 1;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    rst_b = 0;
    calib_done = 0;
    fail_clear = 0;
    strap_lo = 1;
    mute = 0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(14));
    // data strap low selects the host port
    start(0);
    repeat (20) @(posedge clk);
    chk(loading_r === 0 && host_port_enable === 1 && !scl_oe && !sda_oe, "strap");
    chk(ee.starts == 0, "bus busy in host mode");
    strap_lo <= 0;
    $display("test straps done");
    // absent eeprom: every attempt refused, then abort
    start(1);
    wait_end(5000);
    chk(boot_fail_r === 1 && boot_done_r === 0 && ee.starts == 4, "retries");
    chk(ee.first_byte === 8'ha0, "device address");
    repeat (50) @(posedge clk);
    chk(scl_oe === 1 && sda_oe === 1 && host_port_enable === 0, "abort pins");
    fail_clear <= 1;
    @(posedge clk);
    fail_clear <= 0;
    repeat (4) @(posedge clk);
    chk(scl === 1 && sda === 1 && boot_fail_r === 0, "failure clear");
    $display("test abort done");
    // random image, page pointers, fast speed bit and a valid crc
    c = 8'h00;
    for (i = 0; i < 'h39e; i = i + 1) begin
      img[i] = $urandom;
      if (i[6:0] == 7'h7f)
        img[i] = i[9:7] + 1;
      if (i == 1)
        img[i][7] = 1'b1;
      if (i == 'h00f)
        img[i] = BOARD_ADDR;
      if (i >= 'h392)
        img[i] = TAIL_DEFAULT;
      c = crc8(c, img[i]);
      ee.mem[i] = img[i]; // two-byte part, image unshifted
    end
    img['h39e] = c;
    ee.mem['h39e] = c;
    start(0);
    // two bits of the read address byte of the short read
    wait (ee.starts == 2);
    @(posedge scl);
    @(posedge scl);
    @(posedge clk);
    chk(ee.per > STD_NS - 1.0 && ee.per < STD_NS + 1.0, "short read period");
    wait_end(90000);
    chk(boot_done_r === 1 && widx == 'h39f && ee.starts == 4, "full load");
    chk(scl === 1 && sda === 1 && loading_r === 0 && host_port_enable === 1, "idle");
    $display("test load done");
    report_and_stop;
  end
endmodule
